// >>> design/sqd_pkg.sv
// Purpose: shared constants for the squib driver protection and diagnostic block
// Assumes: 25 MHz system clock, APB register access with 32-bit data
// Notes: times are kept in ns and turned into cycle counts here
package sqd_pkg;
	localparam int NCH = 8;
	localparam int CLK_NS = 40;
	// ******************************
	// register byte offsets
	// ******************************
	localparam logic [7:0] OFS_DEPLOY_ENABLE_CMD = 8'h00;
	localparam logic [7:0] OFS_CHANNEL_DEPLOY_CMD = 8'h04;
	localparam logic [7:0] OFS_DEPTIME = 8'h08;
	localparam logic [7:0] OFS_LPREQ = 8'h0C;
	localparam logic [7:0] OFS_LPSTAT = 8'h10;
	localparam logic [7:0] OFS_AUTORES = 8'h14;
	localparam logic [7:0] OFS_IRQSTAT = 8'h18;
	localparam logic [7:0] OFS_IRQMASK = 8'h1C;
	localparam logic [7:0] OFS_DEPSTAT = 8'h20;
	// ******************************
	// loop diagnostic request fields
	// ******************************
	localparam int REQ_MANUAL = 0;
	localparam int REQ_CH_LO = 1;
	localparam int REQ_SIDE = 4;
	localparam int REQ_MON = 5;
	localparam int REQ_SRC = 6;
	localparam int REQ_SNK = 7;
	localparam int REQ_PD = 8;
	localparam int REQ_ADC = 9;
	localparam int REQ_AUTO = 10;
	localparam logic [10:0] REQ_RST = 11'h101;
	// ******************************
	// interrupt status bits
	// ******************************
	localparam int IRQ_SHUT = 0;
	localparam int IRQ_RETRY = 1;
	localparam int IRQ_ADC = 2;
	localparam int IRQ_AUTO = 3;
	localparam int IRQ_DEPOK = 4;
	localparam int IRQ_W = 5;
	// ******************************
	// reset values and timing
	// ******************************
	localparam logic [15:0] DEPTIME_RST = 16'h2710;
	localparam int LS_DLY_NS = 10000;
	localparam int LIM_NS = 20000;
	localparam int LIMOS_NS = 5000;
	localparam int RETRY_OFF_NS = 2000;
	localparam int SETTLE_NS = 100000;
	localparam int ADC_STEP_NS = 1000;
	localparam int LS_DLY_CYC = (LS_DLY_NS + CLK_NS - 1) / CLK_NS;
	localparam int LIM_CYC = (LIM_NS + CLK_NS - 1) / CLK_NS;
	localparam int LIMOS_CYC = (LIMOS_NS + CLK_NS - 1) / CLK_NS;
	localparam int RETRY_OFF_CYC = (RETRY_OFF_NS + CLK_NS - 1) / CLK_NS;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int ADC_STEP_CYC = (ADC_STEP_NS + CLK_NS - 1) / CLK_NS;
	localparam int ADC_BITS = 10;
endpackage

// >>> design/sqd_adc_if.sv
// Purpose: request and result path between the control logic and the converter
// Assumes: one clock domain
// Notes: start is a one-cycle pulse, done a one-cycle pulse with result valid
`timescale 1ns/1ps
interface sqd_adc_if;
	logic start;
	logic busy;
	logic done;
	logic [9:0] result;
	modport ctrl (output start, input busy, input done, input result);
	modport conv (input start, output busy, output done, output result);
endinterface

// >>> design/sqd_adc.sv
// Purpose: ten-bit successive approximation sequencer
// Assumes: external comparator says dac level is below the sampled input when high
// Notes: one bit decided per step enable pulse
`timescale 1ns/1ps
module sqd_adc
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// request path
	sqd_adc_if.conv adc,
	// analog side
	input wire logic i_cmp,
	output logic [9:0] o_dac
);
	logic [9:0] dac_r, dac_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic busy_r, busy_nxt;
	logic done_r, done_nxt;
	logic [4:0] div_r, div_nxt;
	// comparator is asynchronous; two flops of lag sit well inside one step
	logic cmp_q1, cmp_s;
	logic step;

	assign step = (div_r == 5'(sqd_pkg::ADC_STEP_CYC - 1));
	assign adc.busy = busy_r;
	assign adc.done = done_r;
	assign adc.result = dac_r;
	assign o_dac = dac_r;

	always_comb
	begin
		dac_nxt = dac_r;
		bit_nxt = bit_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		div_nxt = (busy_r && !step) ? div_r + 5'h01 : 5'h00;
		if (!busy_r && adc.start)
		begin
			busy_nxt = 1'b1;
			bit_nxt = 4'(sqd_pkg::ADC_BITS - 1);
			dac_nxt = 10'h200;
		end
		else if (busy_r && step)
		begin
			// keep the trial bit only while the input is still above the dac level
			if (!cmp_s)
				dac_nxt[bit_r] = 1'b0;
			if (bit_r == 4'h0)
			begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
			end
			else
			begin
				bit_nxt = bit_r - 4'h1;
				dac_nxt[bit_r - 4'h1] = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			dac_r <= 10'h000;
			bit_r <= 4'h0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
			div_r <= 5'h00;
			cmp_q1 <= 1'b0;
			cmp_s <= 1'b0;
		end
		else
		begin
			dac_r <= dac_nxt;
			bit_r <= bit_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
			div_r <= div_nxt;
			cmp_q1 <= i_cmp;
			cmp_s <= cmp_q1;
		end
	end
endmodule

// >>> design/sqd_chan_prot.sv
// Purpose: per-channel driver sequencing with battery short and open retry protection
// Assumes: limit input already synchronised
// Notes: latched shutdown is cleared only by the accepted new deploy pulse
`timescale 1ns/1ps
module sqd_chan_prot
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// control
	input wire logic i_fire,
	input wire logic i_new_cmd,
	input wire logic i_lim,
	// drivers and events
	output logic o_hs,
	output logic o_ls,
	output logic o_latched,
	output logic o_shut,
	output logic o_retry
);
	typedef enum logic [2:0]
	{
		SQD_OFF = 3'b000,
		SQD_ON = 3'b001,
		SQD_LSDLY = 3'b010,
		SQD_RETRY = 3'b011,
		SQD_LATCH = 3'b100
	} sqd_prot_t;

	sqd_prot_t st_r, st_nxt;
	logic [11:0] tmr_r, tmr_nxt;
	logic [11:0] lim_r, lim_nxt;
	logic shut_nxt, retry_nxt;
	logic shut_r, retry_r;
	logic hs_nxt, ls_nxt;
	logic hs_r, ls_r;

	// drivers come straight from flops so no decode glitch reaches the pins
	assign o_hs = hs_r;
	assign o_ls = ls_r;
	assign o_latched = (st_r == SQD_LATCH);
	assign o_shut = shut_r;
	assign o_retry = retry_r;

	always_comb
	begin
		st_nxt = st_r;
		tmr_nxt = tmr_r + 12'h001;
		shut_nxt = 1'b0;
		retry_nxt = 1'b0;
		// limit time keeps running across a retry so a hard short still trips
		lim_nxt = (i_lim && (st_r == SQD_ON || st_r == SQD_RETRY)) ? lim_r + 12'h001 : 12'h000;
		unique case (st_r)
			SQD_OFF:
			begin
				if (i_fire)
					st_nxt = SQD_ON;
			end
			SQD_ON:
			begin
				tmr_nxt = 12'h000;
				if (!i_fire)
					st_nxt = SQD_LSDLY;
				else if (lim_r == 12'(sqd_pkg::LIMOS_CYC - 1))
				begin
					st_nxt = SQD_RETRY;
					retry_nxt = 1'b1;
				end
			end
			SQD_LSDLY:
			begin
				if (tmr_r == 12'(sqd_pkg::LS_DLY_CYC - 1))
					st_nxt = SQD_OFF;
			end
			SQD_RETRY:
			begin
				if (tmr_r == 12'(sqd_pkg::RETRY_OFF_CYC - 1))
				begin
					st_nxt = i_fire ? SQD_ON : SQD_LSDLY;
					tmr_nxt = 12'h000;
				end
			end
			SQD_LATCH:
			begin
				if (i_new_cmd)
					st_nxt = SQD_OFF;
			end
		endcase
		if (lim_r == 12'(sqd_pkg::LIM_CYC - 1) && st_r != SQD_LATCH)
		begin
			st_nxt = SQD_LATCH;
			shut_nxt = 1'b1;
		end
		hs_nxt = (st_nxt == SQD_ON);
		ls_nxt = (st_nxt == SQD_ON) || (st_nxt == SQD_LSDLY) || (st_nxt == SQD_RETRY);
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			st_r <= SQD_OFF;
			tmr_r <= 12'h000;
			lim_r <= 12'h000;
			shut_r <= 1'b0;
			retry_r <= 1'b0;
			hs_r <= 1'b0;
			ls_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			tmr_r <= tmr_nxt;
			lim_r <= lim_nxt;
			shut_r <= shut_nxt;
			retry_r <= retry_nxt;
			hs_r <= hs_nxt;
			ls_r <= ls_nxt;
		end
	end
endmodule

// >>> design/sqd_top.sv
// Purpose: squib deploy protection sequencing and low-level leakage diagnostic control
// Assumes: APB master on the system clock, analog inputs are asynchronous
// Notes: zero wait-state APB answer one cycle after setup
`timescale 1ns/1ps
module sqd_top
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// arming and analog comparators
	input wire logic [7:0] i_arm,
	input wire logic [7:0] i_ls_limit,
	input wire logic i_battery_short_comparator,
	input wire logic i_ground_short_comparator,
	input wire logic i_adc_cmp,
	// drivers
	output logic [7:0] o_hs_on,
	output logic [7:0] o_ls_on,
	// diagnostic switches
	output logic [7:0] o_source_current_gen,
	output logic [7:0] o_limited_sink_switch,
	output logic [7:0] o_pulldown_en,
	output logic o_regulator_current_monitor,
	output logic [2:0] o_leak_channel_select,
	output logic o_pin_side_select,
	output logic [9:0] o_adc_dac,
	// interrupt
	output logic o_irq
);
	localparam int N = sqd_pkg::NCH;

	// ******************************
	// reset release and input synchronisers
	// ******************************
	logic [1:0] rst_q;
	logic rst_n;
	logic [7:0] arm_q1, arm_s, lim_q1, lim_s;
	logic [1:0] cmp_q1, cmp_s;

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			rst_q <= 2'b00;
		else
			rst_q <= {rst_q[0], 1'b1};
	end
	assign rst_n = rst_q[1];

	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			arm_q1 <= 8'h00;
			arm_s <= 8'h00;
			lim_q1 <= 8'h00;
			lim_s <= 8'h00;
			cmp_q1 <= 2'b00;
			cmp_s <= 2'b00;
		end
		else
		begin
			arm_q1 <= i_arm;
			arm_s <= arm_q1;
			lim_q1 <= i_ls_limit;
			lim_s <= lim_q1;
			cmp_q1 <= {i_ground_short_comparator, i_battery_short_comparator};
			cmp_s <= cmp_q1;
		end
	end

	// ******************************
	// apb decode
	// ******************************
	logic wr, setup;
	logic known;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'b00) && (a <= sqd_pkg::OFS_DEPSTAT);
	endfunction

	assign setup = i_psel && !i_penable;
	assign wr = i_psel && i_penable && o_pready && i_pwrite && mapped(i_paddr);
	assign known = mapped(i_paddr);

	// ******************************
	// register state
	// ******************************
	logic en_r, en_nxt;
	logic [7:0] used_r, used_nxt;
	logic [7:0] act_r, act_nxt;
	logic [7:0] ok_r, ok_nxt;
	logic [15:0] deptime_r, deptime_nxt;
	logic [15:0] dtmr_r [N];
	logic [15:0] dtmr_nxt [N];
	logic [10:0] req_r, req_nxt;
	logic [9:0] adcres_r, adcres_nxt;
	logic [15:0] autores_r, autores_nxt;
	localparam int IRQ_TOP = sqd_pkg::IRQ_W - 1;
	logic [IRQ_TOP:0] ist_r, ist_nxt;
	logic [IRQ_TOP:0] imask_r, imask_nxt;
	logic [7:0] newcmd;
	logic [7:0] fire;
	logic [7:0] latched, shut, retry;
	logic [IRQ_TOP:0] ev;

	// ******************************
	// automatic diagnostic sequence
	// ******************************
	typedef enum logic [1:0]
	{
		SQD_IDLE = 2'b00,
		SQD_SETTLE = 2'b01,
		SQD_SAMPLE = 2'b10
	} sqd_auto_t;

	sqd_auto_t ast_r, ast_nxt;
	logic [3:0] apos_r, apos_nxt;
	logic [11:0] atmr_r, atmr_nxt;
	logic auto_busy, auto_done;
	logic diag_ok;

	sqd_adc_if adc_bus ();

	assign auto_busy = (ast_r != SQD_IDLE);
	// diagnostics are held in reset while deployment is enabled
	assign diag_ok = !en_r;

	always_comb
	begin
		ast_nxt = ast_r;
		apos_nxt = apos_r;
		atmr_nxt = 12'h000;
		autores_nxt = autores_r;
		auto_done = 1'b0;
		unique case (ast_r)
			SQD_IDLE:
			begin
				if (wr && i_paddr == sqd_pkg::OFS_LPREQ && !i_pwdata[sqd_pkg::REQ_MANUAL]
					&& i_pwdata[sqd_pkg::REQ_AUTO] && diag_ok)
				begin
					ast_nxt = SQD_SETTLE;
					apos_nxt = 4'h0;
					autores_nxt = 16'h0000;
				end
			end
			SQD_SETTLE:
			begin
				atmr_nxt = atmr_r + 12'h001;
				if (atmr_r == 12'(sqd_pkg::SETTLE_CYC - 1))
					ast_nxt = SQD_SAMPLE;
			end
			SQD_SAMPLE:
			begin
				// low byte gathers battery faults, high byte ground faults per channel
				autores_nxt[apos_r[3:1]] = autores_r[apos_r[3:1]] | cmp_s[0];
				autores_nxt[8 + 32'(apos_r[3:1])] = autores_r[8 + 32'(apos_r[3:1])] | cmp_s[1];
				apos_nxt = apos_r + 4'h1;
				if (apos_r == 4'hF)
				begin
					ast_nxt = SQD_IDLE;
					auto_done = 1'b1;
				end
				else
					ast_nxt = SQD_SETTLE;
			end
		endcase
		if (!diag_ok)
			ast_nxt = SQD_IDLE;
	end

	// ******************************
	// deploy control and registers
	// ******************************
	always_comb
	begin
		en_nxt = en_r;
		used_nxt = used_r;
		act_nxt = act_r;
		ok_nxt = ok_r;
		deptime_nxt = deptime_r;
		req_nxt = req_r;
		adcres_nxt = adcres_r;
		imask_nxt = imask_r;
		newcmd = 8'h00;
		adc_bus.start = 1'b0;
		ev[sqd_pkg::IRQ_SHUT] = |shut;
		ev[sqd_pkg::IRQ_RETRY] = |retry;
		ev[sqd_pkg::IRQ_ADC] = adc_bus.done;
		ev[sqd_pkg::IRQ_DEPOK] = 1'b0;
		ev[sqd_pkg::IRQ_AUTO] = auto_done;
		for (int c = 0; c < N; c++)
		begin
			dtmr_nxt[c] = dtmr_r[c];
			if (fire[c])
			begin
				dtmr_nxt[c] = dtmr_r[c] + 16'h0001;
				if (dtmr_r[c] == deptime_r)
				begin
					act_nxt[c] = 1'b0;
					ok_nxt[c] = 1'b1;
					ev[sqd_pkg::IRQ_DEPOK] = 1'b1;
				end
			end
		end
		if (adc_bus.done)
			adcres_nxt = adc_bus.result;
		if (wr)
		begin
			unique case (i_paddr)
				sqd_pkg::OFS_DEPLOY_ENABLE_CMD:
				begin
					en_nxt = i_pwdata[0];
					if (!i_pwdata[0])
						used_nxt = 8'h00;
				end
				sqd_pkg::OFS_CHANNEL_DEPLOY_CMD:
				begin
					if (en_r)
					begin
						// a channel already fired needs the global toggle first
						newcmd = i_pwdata[7:0] & ~used_r;
						used_nxt = used_r | newcmd;
						act_nxt = act_r | newcmd;
						ok_nxt = ok_r & ~newcmd;
						for (int c = 0; c < N; c++)
							if (newcmd[c])
								dtmr_nxt[c] = 16'h0000;
					end
				end
				sqd_pkg::OFS_DEPTIME: deptime_nxt = i_pwdata[15:0];
				sqd_pkg::OFS_LPREQ:
				begin
					if (diag_ok && !auto_busy)
					begin
						req_nxt = i_pwdata[10:0];
						adc_bus.start = i_pwdata[sqd_pkg::REQ_ADC] && !adc_bus.busy;
					end
				end
				sqd_pkg::OFS_IRQMASK: imask_nxt = i_pwdata[IRQ_TOP:0];
				default:
				begin
				end
			endcase
		end
		if (!diag_ok)
			req_nxt = sqd_pkg::REQ_RST;
		// sticky flags: a new event beats a same-cycle clear
		ist_nxt = ist_r;
		if (wr && i_paddr == sqd_pkg::OFS_IRQSTAT)
			ist_nxt = ist_r & ~i_pwdata[IRQ_TOP:0];
		ist_nxt = ist_nxt | ev;
	end

	// ******************************
	// diagnostic switch steering
	// ******************************
	logic [7:0] src_nxt, snk_nxt, pd_nxt;
	logic [2:0] dch;
	logic dside, dmon;

	always_comb
	begin
		dch = auto_busy ? apos_r[3:1] : req_r[sqd_pkg::REQ_CH_LO +: 3];
		dside = auto_busy ? apos_r[0] : req_r[sqd_pkg::REQ_SIDE];
		dmon = auto_busy || req_r[sqd_pkg::REQ_MON];
		src_nxt = 8'h00;
		snk_nxt = 8'h00;
		// pull-downs on but the monitored one while the host leaves them enabled or the automatic sequence runs, and all on while deployment is enabled
		pd_nxt = (req_r[sqd_pkg::REQ_PD] || auto_busy) ? 8'hFF : 8'h00;
		if (!auto_busy && req_r[sqd_pkg::REQ_SRC])
			src_nxt[dch] = 1'b1;
		if (!auto_busy && req_r[sqd_pkg::REQ_SNK])
			snk_nxt[dch] = 1'b1;
		if (dmon)
			pd_nxt[dch] = 1'b0;
		if (!diag_ok)
		begin
			src_nxt = 8'h00;
			snk_nxt = 8'h00;
			pd_nxt = 8'hFF;
		end
	end

	// ******************************
	// per channel protection
	// ******************************
	assign fire = act_r & arm_s;

	for (genvar g = 0; g < N; g++)
	begin : g_ch
		sqd_chan_prot u_prot
		(
			.i_clk(i_clk),
			.i_rst_n(rst_n),
			.i_fire(fire[g] && en_r),
			.i_new_cmd(newcmd[g]),
			.i_lim(lim_s[g]),
			.o_hs(o_hs_on[g]),
			.o_ls(o_ls_on[g]),
			.o_latched(latched[g]),
			.o_shut(shut[g]),
			.o_retry(retry[g])
		);
	end

	sqd_adc u_adc
	(
		.i_clk(i_clk),
		.i_rst_n(rst_n),
		.adc(adc_bus),
		.i_cmp(i_adc_cmp),
		.o_dac(o_adc_dac)
	);

	// ******************************
	// read mux
	// ******************************
	logic [31:0] rd;

	always_comb
	begin
		rd = 32'h0000_0000;
		unique case (i_paddr)
			sqd_pkg::OFS_DEPLOY_ENABLE_CMD: rd[0] = en_r;
			sqd_pkg::OFS_CHANNEL_DEPLOY_CMD: rd[7:0] = act_r;
			sqd_pkg::OFS_DEPTIME: rd[15:0] = deptime_r;
			sqd_pkg::OFS_LPREQ: rd[10:0] = req_r;
			sqd_pkg::OFS_LPSTAT:
			begin
				// live comparator state, reported per selected pin
				rd[1:0] = cmp_s;
				rd[4:2] = dch;
				rd[5] = dside;
				rd[6] = auto_busy;
				rd[7] = adc_bus.busy;
				rd[25:16] = adcres_r;
			end
			sqd_pkg::OFS_AUTORES: rd[15:0] = autores_r;
			sqd_pkg::OFS_IRQSTAT: rd[IRQ_TOP:0] = ist_r;
			sqd_pkg::OFS_IRQMASK: rd[IRQ_TOP:0] = imask_r;
			sqd_pkg::OFS_DEPSTAT: rd[23:0] = {ok_r, latched, used_r};
			default: rd = 32'h0000_0000;
		endcase
	end

	// ******************************
	// registers
	// ******************************
	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			en_r <= 1'b0;
			used_r <= 8'h00;
			act_r <= 8'h00;
			ok_r <= 8'h00;
			deptime_r <= sqd_pkg::DEPTIME_RST;
			for (int c = 0; c < N; c++)
				dtmr_r[c] <= 16'h0000;
			req_r <= sqd_pkg::REQ_RST;
			adcres_r <= 10'h000;
			autores_r <= 16'h0000;
			ist_r <= '0;
			imask_r <= '0;
			ast_r <= SQD_IDLE;
			apos_r <= 4'h0;
			atmr_r <= 12'h000;
			o_source_current_gen <= 8'h00;
			o_limited_sink_switch <= 8'h00;
			o_pulldown_en <= 8'hFF;
			o_regulator_current_monitor <= 1'b0;
			o_leak_channel_select <= 3'h0;
			o_pin_side_select <= 1'b0;
			o_prdata <= 32'h0000_0000;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_irq <= 1'b0;
		end
		else
		begin
			en_r <= en_nxt;
			used_r <= used_nxt;
			act_r <= act_nxt;
			ok_r <= ok_nxt;
			deptime_r <= deptime_nxt;
			dtmr_r <= dtmr_nxt;
			req_r <= req_nxt;
			adcres_r <= adcres_nxt;
			autores_r <= autores_nxt;
			ist_r <= ist_nxt;
			imask_r <= imask_nxt;
			ast_r <= ast_nxt;
			apos_r <= apos_nxt;
			atmr_r <= atmr_nxt;
			o_source_current_gen <= src_nxt;
			o_limited_sink_switch <= snk_nxt;
			o_pulldown_en <= pd_nxt;
			o_regulator_current_monitor <= dmon && diag_ok;
			o_leak_channel_select <= dch;
			o_pin_side_select <= dside;
			o_prdata <= setup ? rd : o_prdata;
			o_pready <= setup;
			o_pslverr <= setup && !known;
			o_irq <= |(ist_nxt & imask_nxt);
		end
	end
endmodule

// >>> test/sqd_loops_model.sv
// Purpose: behavioural squib loops with limit and comparator front end
// Assumes: the bench sets one fault pattern per channel
// Notes: outputs follow driver and switch states at once
`timescale 1ns/1ps
module sqd_loops_model
#(
	parameter logic [9:0] LEVEL = 10'h200
)
(
	// drivers and switches
	input wire logic [7:0] i_hs_on,
	input wire logic [7:0] i_ls_on,
	input wire logic [7:0] i_src,
	input wire logic [7:0] i_snk,
	input wire logic [7:0] i_pd,
	input wire logic i_mon,
	input wire logic [2:0] i_ch,
	input wire logic i_side,
	input wire logic [9:0] i_dac,
	// faults
	input wire logic [7:0] i_stb_flt,
	input wire logic [7:0] i_open_flt,
	input wire logic [7:0] i_short_flt,
	// sensed levels
	output logic [7:0] o_limit,
	output logic o_bat,
	output logic o_gnd,
	output logic o_cmp
);
	logic [7:0] others;
	// no current and so no limit once the low side is off
	assign o_limit = i_ls_on & (i_stb_flt | (i_open_flt & i_hs_on));
	assign others = i_pd & ~(8'h01 << i_ch);
	assign o_bat = i_mon & ((!i_side & i_src[i_ch]) | i_stb_flt[i_ch]);
	// a loop short leaks only through the other pulldowns
	assign o_gnd = i_mon & ((i_side & i_snk[i_ch]) | (i_short_flt[i_ch] & |others));
	assign o_cmp = (LEVEL >= i_dac);
endmodule

// >>> test/sqd_top_properties.sv
// Purpose: port checks of bus answer and driver protection timing
// Assumes: channel 0 carries the deploy traffic
// Notes: the limit counter follows the raw limit pin, ahead of the synchronisers
`timescale 1ns/1ps
module sqd_top_properties
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// bus
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic o_pready,
	input wire logic o_pslverr,
	// drivers and diagnostics
	input wire logic [7:0] i_ls_limit,
	input wire logic [7:0] o_hs_on,
	input wire logic [7:0] o_ls_on,
	input wire logic [7:0] o_pulldown_en,
	input wire logic o_regulator_current_monitor,
	input wire logic [2:0] o_leak_channel_select
);
	logic [10:0] off_r;
	logic [10:0] lim_r;
	logic seen_r;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	// seen_r marks a limit hit since the low side came on
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			off_r <= 11'h000;
			lim_r <= 11'h000;
			seen_r <= 1'b0;
		end
		else
		begin
			off_r <= o_hs_on[0] ? 11'h000 : off_r + {10'h000, o_ls_on[0]};
			lim_r <= i_ls_limit[0] ? lim_r + 11'h001 : 11'h000;
			seen_r <= o_ls_on[0] & (seen_r | i_ls_limit[0]);
		end
	end
	setup_answer_a: assert property (i_psel && !i_penable |=> o_pready)
		else $error("setup not answered");
	single_answer_a: assert property (o_pready |=> !o_pready)
		else $error("answer longer than one cycle");
	error_in_access_a: assert property (o_pslverr |-> o_pready && i_psel && i_penable)
		else $error("error outside access");
	high_side_first_a: assert property
		($fell(o_hs_on[0]) && !seen_r |-> o_ls_on[0])
		else $error("low side left with high side");
	low_side_delay_a: assert property
		($fell(o_ls_on[0]) && !seen_r |-> off_r >= sqd_pkg::LS_DLY_CYC - 1
		&& off_r <= sqd_pkg::LS_DLY_CYC + 2)
		else $error("low side delay wrong");
	battery_shutdown_a: assert property
		($fell(o_ls_on[0]) && lim_r != 11'h000 |-> !o_hs_on[0]
		&& lim_r >= sqd_pkg::LIM_CYC && lim_r <= sqd_pkg::LIM_CYC + 5)
		else $error("shutdown timing wrong");
	retry_start_a: assert property
		($fell(o_hs_on[0]) && o_ls_on[0] && lim_r != 11'h000 && lim_r < 2 * sqd_pkg::LIMOS_CYC
		|-> lim_r >= sqd_pkg::LIMOS_CYC && lim_r <= sqd_pkg::LIMOS_CYC + 5)
		else $error("retry start wrong");
	retry_length_a: assert property
		($rose(o_hs_on[0]) && seen_r |-> off_r >= sqd_pkg::RETRY_OFF_CYC - 1
		&& off_r <= sqd_pkg::RETRY_OFF_CYC + 2)
		else $error("retry off time wrong");
	pulldown_drop_a: assert property
		(o_regulator_current_monitor |-> !o_pulldown_en[o_leak_channel_select])
		else $error("monitored pulldown still on");
endmodule
bind sqd_top sqd_top_properties u_props
(
	.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
	.o_pready(o_pready), .o_pslverr(o_pslverr), .i_ls_limit(i_ls_limit),
	.o_hs_on(o_hs_on), .o_ls_on(o_ls_on), .o_pulldown_en(o_pulldown_en),
	.o_regulator_current_monitor(o_regulator_current_monitor),
	.o_leak_channel_select(o_leak_channel_select)
);

// >>> test/sqd_top_test.sv
// Purpose: register level test of deploy protection and leakage diagnostics
// Assumes: apb master on the system clock
// Notes: channel 0 deploys, channel 3 carries the leakage cases
`timescale 1ns/1ps
module sqd_top_test;
	localparam logic [9:0] LEVEL = 10'h2A5;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [7:0] arm = 8'h01;
	logic [7:0] stb = 8'h00;
	logic [7:0] opn = 8'h00;
	logic [7:0] shrt = 8'h00;
	logic [31:0] prdata, rdat;
	logic pready, pslverr, rerr, irq, mon, side, bat, gnd, cmp;
	logic [7:0] hs, ls, src, snk, pd, lim;
	logic [2:0] ch;
	logic [9:0] dac;
	int checks = 0;
	int miscompares = 0;
	logic [31:0] reqs [5] = '{32'h167, 32'h1B7, 32'h127, 32'h027, 32'h127};
	logic [5:0] stat [5] = '{6'h0D, 6'h2E, 6'h0E, 6'h0C, 6'h0C};
	logic [7:0] pds [5] = '{8'hF7, 8'hF7, 8'hF7, 8'h00, 8'hF7};
	sqd_top u_dut
	(
		.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_arm(arm), .i_ls_limit(lim),
		.i_battery_short_comparator(bat), .i_ground_short_comparator(gnd),
		.i_adc_cmp(cmp), .o_hs_on(hs), .o_ls_on(ls), .o_source_current_gen(src),
		.o_limited_sink_switch(snk), .o_pulldown_en(pd),
		.o_regulator_current_monitor(mon), .o_leak_channel_select(ch),
		.o_pin_side_select(side), .o_adc_dac(dac), .o_irq(irq)
	);
	sqd_loops_model #(.LEVEL(LEVEL)) u_loops
	(
		.i_hs_on(hs), .i_ls_on(ls), .i_src(src), .i_snk(snk), .i_pd(pd), .i_mon(mon),
		.i_ch(ch), .i_side(side), .i_dac(dac), .i_stb_flt(stb), .i_open_flt(opn),
		.i_short_flt(shrt), .o_limit(lim), .o_bat(bat), .o_gnd(gnd), .o_cmp(cmp)
	);
	always #20 clk = ~clk;
	task automatic conclude();
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e)
		begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// one idle cycle before each setup keeps every signal to one change per step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
		begin
			miscompares++;
			conclude();
		end
	endtask
	task automatic wt(input logic v, input logic use_irq, input int lim_cyc);
		int n;
		n = 0;
		while (((use_irq ? irq : hs[0]) !== v) && n < lim_cyc)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= lim_cyc)
		begin
			miscompares++;
			conclude();
		end
	endtask
	task automatic rearm();
		apb(1'b1, sqd_pkg::OFS_DEPLOY_ENABLE_CMD, 32'h0);
		apb(1'b1, sqd_pkg::OFS_DEPLOY_ENABLE_CMD, 32'h1);
		apb(1'b1, sqd_pkg::OFS_CHANNEL_DEPLOY_CMD, 32'h1);
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		apb(1'b0, sqd_pkg::OFS_LPREQ, 32'h0);
		chk(rdat, {21'h000000, sqd_pkg::REQ_RST});
		apb(1'b0, sqd_pkg::OFS_DEPTIME, 32'h0);
		chk(rdat, {16'h0000, sqd_pkg::DEPTIME_RST});
		chk(pd, 8'hFF);
		apb(1'b0, 8'h40, 32'h0);
		chk(rerr, 1'b1);
		apb(1'b1, sqd_pkg::OFS_DEPTIME, 32'h3E8);
		apb(1'b1, sqd_pkg::OFS_IRQMASK, 32'h10);
		rearm();
		wt(1'b1, 1'b0, 3000);
		wt(1'b0, 1'b0, 3000);
		chk(ls[0], 1'b1);
		wt(1'b1, 1'b1, 300);
		apb(1'b0, sqd_pkg::OFS_DEPSTAT, 32'h0);
		chk(rdat[16], 1'b1);
		apb(1'b1, sqd_pkg::OFS_IRQSTAT, 32'h1F);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		repeat (300) @(posedge clk);
		stb <= 8'h01;
		rearm();
		wt(1'b1, 1'b0, 3000);
		repeat (600) @(posedge clk);
		chk({hs[0], ls[0]}, 2'b00);
		apb(1'b0, sqd_pkg::OFS_DEPSTAT, 32'h0);
		chk(rdat[8], 1'b1);
		stb <= 8'h00;
		apb(1'b1, sqd_pkg::OFS_CHANNEL_DEPLOY_CMD, 32'h1);
		repeat (20) @(posedge clk);
		chk(hs[0], 1'b0);
		rearm();
		wt(1'b1, 1'b0, 3000);
		wt(1'b0, 1'b0, 3000);
		repeat (300) @(posedge clk);
		apb(1'b0, sqd_pkg::OFS_IRQSTAT, 32'h0);
		chk(rdat[1:0], 2'b11);
		apb(1'b1, sqd_pkg::OFS_IRQSTAT, 32'h1F);
		opn <= 8'h01;
		rearm();
		wt(1'b1, 1'b0, 3000);
		wt(1'b0, 1'b0, 3000);
		chk(ls[0], 1'b1);
		opn <= 8'h00;
		wt(1'b1, 1'b0, 100);
		apb(1'b0, sqd_pkg::OFS_IRQSTAT, 32'h0);
		chk(rdat[1], 1'b1);
		wt(1'b0, 1'b0, 3000);
		repeat (300) @(posedge clk);
		apb(1'b1, sqd_pkg::OFS_LPREQ, 32'h167);
		apb(1'b0, sqd_pkg::OFS_LPREQ, 32'h0);
		chk(rdat, 32'h101);
		apb(1'b1, sqd_pkg::OFS_DEPLOY_ENABLE_CMD, 32'h0);
		for (int i = 0; i < 5; i++)
		begin
			shrt <= (i == 2 || i == 3) ? 8'h08 : 8'h00;
			apb(1'b1, sqd_pkg::OFS_LPREQ, reqs[i]);
			repeat (4) @(posedge clk);
			apb(1'b0, sqd_pkg::OFS_LPSTAT, 32'h0);
			chk(rdat[5:0], stat[i]);
			chk(pd, pds[i]);
		end
		apb(1'b1, sqd_pkg::OFS_IRQMASK, 32'h04);
		apb(1'b1, sqd_pkg::OFS_LPREQ, 32'h341);
		wt(1'b1, 1'b1, 1000);
		apb(1'b0, sqd_pkg::OFS_LPSTAT, 32'h0);
		chk(rdat[25:16], LEVEL);
		apb(1'b1, sqd_pkg::OFS_IRQMASK, 32'h08);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		apb(1'b0, sqd_pkg::OFS_IRQSTAT, 32'h0);
		chk(rdat[2], 1'b1);
		apb(1'b1, sqd_pkg::OFS_IRQSTAT, 32'h1F);
		shrt <= 8'h08;
		apb(1'b1, sqd_pkg::OFS_LPREQ, 32'h500);
		wt(1'b1, 1'b1, 45000);
		apb(1'b0, sqd_pkg::OFS_LPSTAT, 32'h0);
		chk(rdat[6], 1'b0);
		apb(1'b0, sqd_pkg::OFS_AUTORES, 32'h0);
		chk(rdat[15:0], 16'h0800);
		apb(1'b1, sqd_pkg::OFS_IRQSTAT, 32'h08);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		conclude();
	end
endmodule
